// ===== fault_pin_ctl.sv
// drives the open-drain style fault output pin for clock-monitor errors
// assumes the clock-ok level is already synchronous to mclk_i
`timescale 1ns/1ps
module fault_pin_ctl
  import rst_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic in_reset_i,
  input wire logic cm_enable_i,
  input wire logic clk_ok_i,
  input wire logic idle_tick_i,
  output logic cm_error_o,
  output logic fault_n_o
);

  logic [3:0] ok_count;
  logic err;
  wire detect = cm_enable_i && !in_reset_i && !clk_ok_i;
  wire count_done = (ok_count == FAULT_HOLD_MIN);

  // ===========================================================
  // error set on slow clock after reset, cleared on the 16th tick after recovery
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      err <= 1'b0;
      ok_count <= '0;
    end
    else if (detect)
    begin
      err <= 1'b1;
      ok_count <= '0;
    end
    else if (err && clk_ok_i && idle_tick_i)
    begin
      ok_count <= ok_count + 4'h1;
      if (count_done)
      begin
        err <= 1'b0;
      end
    end
  end

  assign cm_error_o = err;
  // pin low while the error stands
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fault_n_o <= 1'b1;
    end
    else
    begin
      fault_n_o <= !err;
    end
  end

  AST_FAULT_LOW: assert property (@(posedge mclk_i) disable iff (reset_i)
    err |=> !fault_n_o) else $error("fault pin not low on error");
  AST_ERR_SETS: assert property (@(posedge mclk_i) disable iff (reset_i)
    detect |=> err) else $error("clock monitor error missed");

endmodule

// ===== level_sync.sv
// two-flop synchroniser for the analog comparator levels
// assumes levels that move slowly compared with the clock
`timescale 1ns/1ps
module level_sync
  import rst_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire supply_t raw_i,
  output supply_t sync_o
);

  supply_t stage;

  // ===========================================================
  // first stage is read only by the second stage
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stage <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage <= raw_i;
      sync_o <= stage;
    end
  end

endmodule

// ===== reset_and_brownout_sequencer.sv
// reset sequencer: external pin, brownout detector, power-on delay, idle timer
// assumes comparator levels are async digital inputs; everything else is synchronous
`timescale 1ns/1ps

// Notes on behaviour
// - watchdog and clock monitor held inactive while any reset is active.
// - reset sets watchdog window bits high, selecting the largest window.
// - reset sets clock monitor enable; slow clock after reset flags error.
// - error drives fault pin low until 16-32 idle ticks after clock ok.
// - external reset initialises the device and ends halt mode.
// - below brownout threshold hold reset and preset idle timer near 0x00f0.
// - above threshold idle timer counts down; underflow releases reset.
// - brownout reset initialises exactly as the external reset does.
// - later supply drop re-asserts reset, presets timer, restarts countdown.
// - deep drop below trigger forces about 3 ms delay after recovery.
// - countdown starts only when delay done and supply above threshold.
// - shallow dip skips the power-on delay entirely.
// - no further internal reset while supply stays above threshold.
// - brownout disabled: no internal reset, timer value undefined.
// - data registers and memory are not initialised by on-chip reset.
// - option bit zero routes fault output to pin; otherwise general port.
module reset_and_brownout_sequencer
  import rst_pkg::*;
#(
  parameter int unsigned POWER_ON_CYC = POWER_ON_DELAY_CYC
)
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ext_reset_n_i,
  input wire logic bor_enable_i,
  input wire logic above_bor_i,
  input wire logic above_trig_i,
  input wire logic clk_ok_i,
  input wire logic opt_wd_bit_i,
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  input wire logic halted_i,
  output logic core_reset_o,
  output logic halt_exit_o,
  output guard_t guard_o,
  output logic [7:0] idle_timer_o,
  output logic idle_tick_o,
  output logic cm_error_o,
  output logic fault_pin_o,
  output logic fault_pin_oe_o
);

  // ===========================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_DEEP = 4'h1,
    ST_DELAY = 4'h2,
    ST_HOLD = 4'h4,
    ST_RUN = 4'h8
  } seq_state_t;

  seq_state_t state;
  seq_state_t next_state;
  supply_t sup;
  logic [DLY_W-1:0] dly_count;
  logic [7:0] idle;
  logic bor_reset;
  logic fault_n;
  logic opt_wd;
  supply_t raw_sup;

  // ===========================================================
  // comparator inputs cross into the clock domain
  // packed here so both levels share one synchroniser and one latency
  assign raw_sup = '{above_bor: above_bor_i, above_trig: above_trig_i};
  level_sync u_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .raw_i(raw_sup),
    .sync_o(sup)
  );

  // ===========================================================
  // decode of supply conditions
  wire delay_done = (dly_count == '0);
  wire underflow = (state == ST_HOLD) && (idle == 8'h00);
  wire ext_reset = !ext_reset_n_i;
  // the brownout path is gated here so a part without it never resets itself
  wire any_reset = ext_reset || (bor_enable_i && bor_reset);

  // next-state choice; shallow dips return to hold without the delay
  always_comb
  begin
    next_state = state;
    case (state)
      ST_DEEP:
        if (sup.above_trig) next_state = ST_DELAY;
      ST_DELAY:
        if (!sup.above_trig) next_state = ST_DEEP;
        else if (delay_done && sup.above_bor) next_state = ST_HOLD;
      ST_HOLD:
        if (!sup.above_trig) next_state = ST_DEEP;
        else if (underflow) next_state = ST_RUN;
      ST_RUN:
        if (!sup.above_trig) next_state = ST_DEEP;
        else if (!sup.above_bor) next_state = ST_HOLD;
      default:
        next_state = ST_DEEP;
    endcase
  end

  // ===========================================================
  // state register and power-on delay counter
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state <= ST_DEEP;
      dly_count <= '0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_DEEP)
      begin
        dly_count <= DLY_W'(POWER_ON_CYC - 1);
      end
      else if (!delay_done)
      begin
        dly_count <= dly_count - 1'b1;
      end
    end
  end

  // idle timer: preset while supply is low, count down above threshold
  // with brownout disabled the timer is simply left free running from its
  // reset value; software must not rely on it
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      idle <= IDLE_PRESET;
    end
    else if (bor_enable_i && (state != ST_RUN) && !(state == ST_HOLD && sup.above_bor))
    begin
      idle <= IDLE_PRESET;
    end
    else
    begin
      idle <= idle - 8'h01;
    end
  end

  // ===========================================================
  // internal reset is released only by underflow
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bor_reset <= 1'b1;
    end
    else
    begin
      bor_reset <= bor_enable_i && (next_state != ST_RUN);
    end
  end

  // external reset also wakes from halt, flagged one cycle later
  // registered so the core sees a clean level, at the cost of one cycle
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      halt_exit_o <= 1'b0;
    end
    else
    begin
      halt_exit_o <= ext_reset && halted_i;
    end
  end

  // ===========================================================
  // one reset line for both sources keeps initialisation identical
  assign core_reset_o = any_reset;

  // guard values forced while reset is active; data memory is untouched
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      guard_o <= '{wd_inhibit: 1'b1, wd_window: WD_WIN_RESET, cm_enable: 1'b1};
      opt_wd <= OPT_WD_BIT_RESET;
    end
    else
    begin
      guard_o.wd_inhibit <= any_reset;
      if (any_reset)
      begin
        guard_o.wd_window <= WD_WIN_RESET;
        guard_o.cm_enable <= 1'b1;
        opt_wd <= opt_wd_bit_i;
      end
    end
  end

  assign idle_timer_o = idle;
  assign idle_tick_o = (state == ST_RUN) || !bor_enable_i;

  // ===========================================================
  // clock monitor fault output
  fault_pin_ctl u_fault (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .in_reset_i(guard_o.wd_inhibit),
    .cm_enable_i(guard_o.cm_enable),
    .clk_ok_i(clk_ok_i),
    .idle_tick_i(idle_tick_o),
    .cm_error_o(cm_error_o),
    .fault_n_o(fault_n)
  );

  // weak pull-up modelled as released pin; in fault mode only low is driven, as a port gpio_out_i is driven
  assign fault_pin_o = opt_wd ? gpio_out_i : 1'b0;
  assign fault_pin_oe_o = opt_wd ? gpio_oe_i : !fault_n;

  // ===========================================================
  // checks
  AST_GUARD_INHIBIT: assert property (@(posedge mclk_i) disable iff (reset_i)
    any_reset |=> guard_o.wd_inhibit) else $error("watchdog not inhibited");
  AST_WIN_HIGH: assert property (@(posedge mclk_i) disable iff (reset_i)
    any_reset |=> guard_o.wd_window == WD_WIN_RESET) else $error("window not max");
  AST_PRESET: assert property (@(posedge mclk_i) disable iff (reset_i)
    (bor_enable_i && state == ST_DEEP) |=> idle == IDLE_PRESET) else $error("no preset");
  AST_HOLD_RESET: assert property (@(posedge mclk_i) disable iff (reset_i)
    (bor_enable_i && state == ST_HOLD && !underflow) |-> core_reset_o)
    else $error("reset dropped early");
  AST_DIP_RESET: assert property (@(posedge mclk_i) disable iff (reset_i)
    (bor_enable_i && state == ST_RUN && !sup.above_bor) |=> ##1 core_reset_o)
    else $error("dip not reset");
  AST_SHALLOW: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state == ST_RUN && sup.above_trig && !sup.above_bor) |=> state == ST_HOLD)
    else $error("shallow dip took delay");
  AST_NO_EXTRA: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state == ST_RUN && sup.above_bor && sup.above_trig) |=> !bor_reset)
    else $error("spurious reset");
  AST_NO_BOR: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!bor_enable_i && $past(!bor_enable_i) && ext_reset_n_i) |-> !core_reset_o)
    else $error("reset with brownout off");
  AST_DELAY_GATE: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state == ST_DELAY && !delay_done) |=> state != ST_HOLD)
    else $error("countdown before delay");

  // ===========================================================
  // further checks on the sequencer and the guard outputs

  // clock monitor must be armed by every reset
  AST_CM_ARMED: assert property (@(posedge mclk_i) disable iff (reset_i)
    any_reset |=> guard_o.cm_enable) else $error("monitor not armed");

  // inhibit must drop once no reset source is active
  AST_GUARD_FREE: assert property (@(posedge mclk_i) disable iff (reset_i)
    !any_reset |=> !guard_o.wd_inhibit) else $error("watchdog stuck off");

  // external reset while halted must wake the core
  AST_HALT_WAKE: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ext_reset && halted_i) |=> halt_exit_o) else $error("no halt exit");

  // no wake flag without the pin
  AST_HALT_QUIET: assert property (@(posedge mclk_i) disable iff (reset_i)
    !ext_reset |=> !halt_exit_o) else $error("stray halt exit");

  // any drop below the trigger level restarts from the deep state
  AST_DEEP_AGAIN: assert property (@(posedge mclk_i) disable iff (reset_i)
    !sup.above_trig |=> state == ST_DEEP) else $error("deep drop missed");

  // the delay counter is reloaded for as long as the supply stays deep
  AST_DELAY_LOAD: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state == ST_DEEP) |=> dly_count == DLY_W'(POWER_ON_CYC - 1))
    else $error("delay not reloaded");

  // above threshold in hold the idle timer steps down by one each cycle
  AST_HOLD_COUNT: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state == ST_HOLD && sup.above_bor && idle != 8'h00) |=> idle == $past(idle) - 8'h01)
    else $error("idle timer stalled");

  // underflow with a good supply ends the internal reset
  AST_UNDERFLOW_RUN: assert property (@(posedge mclk_i) disable iff (reset_i)
    (bor_enable_i && underflow && sup.above_trig) |=> (state == ST_RUN && !bor_reset))
    else $error("underflow kept reset");

  // in watchdog mode an error pulls the pin low
  AST_PIN_ROUTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!opt_wd && !fault_n) |-> (fault_pin_oe_o && !fault_pin_o))
    else $error("fault not on pin");

  // with the brownout path absent only the pin can reset the core
  AST_PIN_ONLY: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!bor_enable_i && ext_reset_n_i) |-> !core_reset_o)
    else $error("internal reset with brownout off");

endmodule

// ===== reset_and_brownout_sequencer_bench.sv
// self-checking bench for the reset and brownout sequencer
// assumes the board model drives the supply levels and the reset pin
`timescale 1ns/1ps
module reset_and_brownout_sequencer_bench;
  import rst_pkg::*;
  localparam int P = 20;
  localparam int HOLD = int'(IDLE_PRESET) + 1;
  typedef struct {logic [1:0] first; logic [1:0] second; int hold; int lo; int hi;} row_t;
  // supply shapes: power-up, shallow dip, deep dip, slow rise past the delay
  row_t rows [4] = '{'{2'h0, 2'h0, 4, P+HOLD, P+HOLD+8}, '{2'h1, 2'h1, 10, HOLD, HOLD+8},
    '{2'h0, 2'h0, 10, P+HOLD, P+HOLD+8}, '{2'h0, 2'h1, 40, HOLD, HOLD+8}};
  logic mclk_i = 1'b0;
  logic reset_i, bor_en, clk_ok, opt_wd, gpio_out, gpio_oe, halted, rst_req;
  logic [1:0] level;
  logic ext_n, above_bor, above_trig, core_reset_o, halt_exit_o, cm_error_o;
  logic fault_pin_o, fault_pin_oe_o, saw, idle_tick;
  logic [7:0] idle_timer_o;
  guard_t guard_o;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n;

  // ==========================================================
  // clock, watchdog on the run length
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_errors++;
      close_out();
    end
  end

  supply_board_model board (.mclk_i(mclk_i), .level_i(level), .rst_req_i(rst_req),
    .ext_reset_n_o(ext_n), .above_bor_o(above_bor), .above_trig_o(above_trig));

  reset_and_brownout_sequencer #(.POWER_ON_CYC(P)) DUT (.mclk_i(mclk_i), .reset_i(reset_i),
    .ext_reset_n_i(ext_n), .bor_enable_i(bor_en), .above_bor_i(above_bor),
    .above_trig_i(above_trig), .clk_ok_i(clk_ok), .opt_wd_bit_i(opt_wd),
    .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .halted_i(halted),
    .core_reset_o(core_reset_o), .halt_exit_o(halt_exit_o), .guard_o(guard_o),
    .idle_timer_o(idle_timer_o), .idle_tick_o(idle_tick), .cm_error_o(cm_error_o),
    .fault_pin_o(fault_pin_o), .fault_pin_oe_o(fault_pin_oe_o));

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait, sampled at the falling edge where outputs are settled
  task automatic wait_rel(output int k);
    k = 0;
    while (core_reset_o !== 1'b0 && k < 600)
    begin
      @(negedge mclk_i);
      k++;
    end
  endtask

  task automatic pulse_pin();
    @(posedge mclk_i) rst_req <= 1'b1;
    @(posedge mclk_i) rst_req <= 1'b0;
  endtask

  task automatic close_out();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    reset_i = 1'b1;
    level = 2'h0;
    rst_req = 1'b0;
    bor_en = 1'b1;
    clk_ok = 1'b1;
    opt_wd = 1'b0;
    gpio_out = 1'b0;
    gpio_oe = 1'b0;
    halted = 1'b0;
    repeat (20) @(posedge mclk_i);
    @(negedge mclk_i);
    check(core_reset_o, 1);
    check(guard_o, {1'b1, WD_WIN_RESET, 1'b1});
    check(idle_timer_o, IDLE_PRESET);
    check(fault_pin_oe_o, 0);
    check(idle_tick, 0);
    @(posedge mclk_i) reset_i <= 1'b0;
    // supply shapes, each ending in a full release and a quiet stretch
    foreach (rows[i])
    begin
      @(posedge mclk_i) level <= rows[i].first;
      repeat (4) @(posedge mclk_i);
      level <= rows[i].second;
      repeat (rows[i].hold) @(posedge mclk_i);
      @(negedge mclk_i);
      check(core_reset_o, 1);
      check(idle_timer_o, IDLE_PRESET);
      check(guard_o, {1'b1, WD_WIN_RESET, 1'b1});
      @(posedge mclk_i) level <= 2'h2;
      wait_rel(n);
      check(n >= rows[i].lo && n <= rows[i].hi, 1);
      saw = 1'b0;
      repeat (300)
      begin
        @(negedge mclk_i);
        saw |= core_reset_o;
      end
      check(saw, 0);
      check(guard_o.wd_inhibit, 0);
      check(idle_tick, 1);
    end
    // pin reset while halted and with a slow clock
    @(posedge mclk_i) clk_ok <= 1'b0;
    halted <= 1'b1;
    pulse_pin();
    saw = 1'b0;
    repeat (6)
    begin
      @(negedge mclk_i);
      saw |= halt_exit_o;
    end
    check(saw, 1);
    check(cm_error_o, 1);
    check({fault_pin_o, fault_pin_oe_o}, 2'h1);
    @(posedge mclk_i) clk_ok <= 1'b1;
    halted <= 1'b0;
    n = 0;
    while (fault_pin_oe_o !== 1'b0 && n < 100)
    begin
      @(negedge mclk_i);
      n++;
    end
    check(n >= 16 && n <= 34, 1);
    check(cm_error_o, 0);
    // option bit set: the pin becomes a plain port
    @(posedge mclk_i) opt_wd <= 1'b1;
    gpio_out <= 1'b1;
    gpio_oe <= 1'b1;
    pulse_pin();
    repeat (4) @(negedge mclk_i);
    check({fault_pin_o, fault_pin_oe_o}, 2'h3);
    @(posedge mclk_i) gpio_out <= 1'b0;
    gpio_oe <= 1'b0;
    repeat (2) @(negedge mclk_i);
    check({fault_pin_o, fault_pin_oe_o}, 2'h0);
    // brownout absent: only the pin can reset the core
    @(posedge mclk_i) bor_en <= 1'b0;
    level <= 2'h0;
    reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (5) @(negedge mclk_i);
    check(core_reset_o, 0);
    check(idle_tick, 1);
    @(posedge mclk_i) rst_req <= 1'b1;
    @(negedge mclk_i);
    check(core_reset_o, 1);
    @(posedge mclk_i) rst_req <= 1'b0;
    close_out();
  end
endmodule

// ===== rst_pkg.sv
// shared constants and carrier types for the reset and brownout sequencer
// assumes a single 250 MHz instruction-cycle clock feeding every module
package rst_pkg;

  // ===========================================================
  // timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned POWER_ON_DELAY_US = 3000;
  localparam int unsigned POWER_ON_DELAY_CYC = POWER_ON_DELAY_US * CLK_MHZ;
  localparam int unsigned DLY_W = 20;
  localparam logic [7:0] IDLE_PRESET = 8'hf0;
  localparam logic [3:0] FAULT_HOLD_MIN = 4'hf;
  localparam int unsigned WD_WIN_W = 2;
  localparam logic [WD_WIN_W-1:0] WD_WIN_RESET = 2'h3;
  localparam logic OPT_WD_BIT_RESET = 1'b0;

  // ===========================================================
  // supply levels after synchronising
  typedef struct packed {
    logic above_bor;
    logic above_trig;
  } supply_t;

  // control state presented to watchdog and clock monitor
  typedef struct packed {
    logic wd_inhibit;
    logic [WD_WIN_W-1:0] wd_window;
    logic cm_enable;
  } guard_t;

endpackage

// ===== supply_board_model.sv
// board side: supply comparators and the external reset circuit
// assumes level_i and rst_req_i change just after a rising edge of mclk_i
`timescale 1ns/1ps
module supply_board_model
(
  input wire logic mclk_i,
  input wire logic [1:0] level_i,
  input wire logic rst_req_i,
  output logic ext_reset_n_o,
  output logic above_bor_o,
  output logic above_trig_o
);
  logic req_seen = 1'b0;

  // ==========================================================
  // external reset circuit
  // stretch each request so the pin stays low across a full cycle
  always @(posedge mclk_i)
  begin
    req_seen <= rst_req_i;
  end
  assign ext_reset_n_o = !(rst_req_i || req_seen);

  // ==========================================================
  // supply comparators: 0 off, 1 above trigger only, 2 above brownout
  assign above_trig_o = (level_i != 2'h0);
  assign above_bor_o = (level_i == 2'h2);
endmodule
